/* File: dv/converter_model.sv */
// converter side model: takes interleaved words, prompt or slow
`timescale 1ns/10ps
module converter_model
	import cascade_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// control from bench
	input wire logic stall,
	input wire logic slow,
	// word handshake
	input wire logic valid,
	output logic ready,
	output int taken
);
	logic ph_q;

	// slow mode takes every other cycle; no word is ever requested twice
	assign ready = !stall && (!slow || ph_q);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ph_q <= 1'b0;
			taken <= 0;
		end else begin
			ph_q <= ~ph_q;
			if (valid && ready) begin
				taken <= taken + 1;
			end
		end
	end
endmodule : converter_model

/* File: dv/tb.sv */
// self-checking bench for the cascaded readout sequencer
`timescale 1ns/10ps
module tb
	import cascade_pkg::*;
;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic tok = 1'b0;
	logic sclk = 1'b0;
	logic comp = 1'b0;
	logic stall = 1'b0;
	logic slow = 1'b1;
	logic mon = 1'b0;
	logic word_valid, word_ready, tok_out, word_dev, word_low, fwd, rev, busy, rate, ovr;
	logic [CHANNEL_W-1:0] word_ch;
	logic [7:0] j;
	int taken;
	int k = 0;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;

	cascaded_readout_sequencer i_dut (.CORE_CLK(core_clk), .RESETN(resetn),
		.SCAN_TOKEN_IN(tok), .SCAN_CLOCK(sclk), .COMPENSATION_STROBE(comp),
		.SCAN_TOKEN_OUT(tok_out), .WORD_VALID(word_valid), .WORD_READY(word_ready),
		.WORD_DEVICE(word_dev), .WORD_LOWER(word_low), .WORD_CHANNEL(word_ch),
		.INJECT_FORWARD(fwd), .INJECT_REVERSE(rev), .READ_BUSY(busy),
		.RATE_FAULT(rate), .OVERRUN(ovr));

	converter_model i_conv (.clk(core_clk), .resetn(resetn), .stall(stall), .slow(slow),
		.valid(word_valid), .ready(word_ready), .taken(taken));

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	task automatic wait_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask : wait_n

	task automatic token_pulse;
		tok = 1'b1;
		wait_n(6);
		check("token_out_high", tok_out, 1'b1);
		tok = 1'b0;
		wait_n(6);
	endtask : token_pulse

	// pin levels stand well beyond the filter's two cycles
	task automatic scan(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			wait_n(half);
			sclk = 1'b0;
			wait_n(half);
			if (i == 0 && half > 8) check("token_out_drop", tok_out, 1'b0);
		end
	endtask : scan

	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// a handshake seen at the falling edge completes at the next rising edge
	always @(negedge core_clk) begin
		if (mon && word_valid === 1'b1 && word_ready === 1'b1) begin
			k++;
			j = 8'(k - 1) >> 1;
			check("word", {word_dev, word_low, word_ch}, {k[0] == 1'b0, j[0],
				j[0] ? 6'h1F - j[6:1] : 6'h3F - j[6:1]});
		end
	end

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic full_read;
		mon = 1'b1;
		token_pulse();
		check("busy", busy, 1'b1);
		scan(128, 10);
		wait_n(10);
		check("count", 8'(k), 8'h80);
		check("taken", 8'(taken), 8'h80);
		check("busy_end", busy, 1'b0);
		check("flags", {rate, ovr}, 2'h0);
		scan(2, 10);
		check("extra", 8'(k), 8'h80);
		mon = 1'b0;
	endtask : full_read

	task automatic strobe(input logic lvl);
		logic [7:0] hit = 8'h00;
		logic [7:0] miss = 8'h00;
		comp = lvl;
		repeat (12) begin
			@(negedge core_clk);
			hit += 8'((lvl ? rev : fwd) === 1'b1);
			miss += 8'((lvl ? fwd : rev) === 1'b1);
		end
		check("inject", {hit[3:0], miss[3:0]}, 8'h10);
	endtask : strobe

	task automatic faults;
		stall = 1'b1;
		token_pulse();
		scan(3, 4);
		wait_n(8);
		check("fault_flags", {rate, ovr, word_valid}, 3'h7);
		stall = 1'b0;
		// prompt converter drains both held words back to back
		slow = 1'b0;
		wait_n(6);
		check("drained", word_valid, 1'b0);
		token_pulse();
		check("cleared", {rate, ovr}, 2'h0);
	endtask : faults

	initial begin
		wait_n(8);
		resetn = 1'b1;
		wait_n(2);
		full_read();
		strobe(1'b1);
		strobe(1'b0);
		faults();
		give_verdict();
	end
endmodule : tb

/* File: rtl/cascade_pkg.sv */
// constants and types shared by the cascaded readout sequencer
// Function
// - token output drops one clock after token input falls, at first falling edge
// - second device presents first value on second rising clock edge of read
// - four-clock cycle: dev1 upper, dev2 upper, dev1 lower, dev2 lower
// - combined word rate at most 15 MHz; converter samples at least that fast
// - falling compensation strobe injects programmed charge into every integrator
// - rising compensation strobe injects equal charge of opposite sign
// - high token input pulse starts a read and clears channel counter
// - upper driver channels 63..32, lower 31..0, lower lags two clocks
// - each device presents a new value every second rising clock edge
package cascade_pkg;

	// ----------------------------------------------------------------
	// word layout and counts
	// ----------------------------------------------------------------
	localparam int CHANNEL_W = 6;
	localparam int WORD_W = CHANNEL_W + 2;
	localparam int EDGE_W = 8;
	localparam int DEVICE_BIT = WORD_W - 1;
	localparam int LOWER_BIT = WORD_W - 2;
	localparam logic [EDGE_W-1:0] LAST_EDGE = 8'h80;
	localparam logic [EDGE_W-1:0] EDGE_RESET = 8'h00;
	localparam logic [CHANNEL_W-1:0] FIRST_CHANNEL = 6'h3F;
	localparam logic [CHANNEL_W-1:0] LOWER_TOP = 6'h1F;
	localparam int PIN_COUNT = 3;
	localparam int PIN_TOKEN = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_COMP = 2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint CORE_CLK_HZ = 250_000_000;
	localparam longint WORD_RATE_MAX_HZ = 15_000_000;
	// least word spacing, rounded up to whole core cycles
	localparam int WORD_GAP_CYCLES =
		int'((CORE_CLK_HZ + WORD_RATE_MAX_HZ - 1) / WORD_RATE_MAX_HZ);
	localparam int GAP_W = 5;
	localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(WORD_GAP_CYCLES);
	localparam logic [GAP_W-1:0] GAP_MAX = 5'h1F;

	// ----------------------------------------------------------------
	// read sequencing states, gray along idle-armed-reading-done
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARMED = 2'h1,
		ST_READING = 2'h3,
		ST_DONE = 2'h2
	} read_state_type;

endpackage : cascade_pkg

/* File: rtl/cascaded_readout_sequencer.sv */
// readout sequencer for two cascaded 64-channel front ends
`timescale 1ns/10ps
module cascaded_readout_sequencer
	import cascade_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	// shared front end control pins
	input wire logic SCAN_TOKEN_IN,
	input wire logic SCAN_CLOCK,
	input wire logic COMPENSATION_STROBE,
	// cascade token
	output logic SCAN_TOKEN_OUT,
	// interleaved word stream to the converter
	output logic WORD_VALID,
	input wire logic WORD_READY,
	output logic WORD_DEVICE,
	output logic WORD_LOWER,
	output logic [CHANNEL_W-1:0] WORD_CHANNEL,
	// compensation injection events
	output logic INJECT_FORWARD,
	output logic INJECT_REVERSE,
	// status
	output logic READ_BUSY,
	output logic RATE_FAULT,
	output logic OVERRUN
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [PIN_COUNT-1:0] pins;
	logic [PIN_COUNT-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, prev_q;

	assign pins = {COMPENSATION_STROBE, SCAN_CLOCK, SCAN_TOKEN_IN};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
			// a level only counts once the second and third stages agree
			always_comb begin
				lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
			end
			always_ff @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					lvl_q[gi] <= 1'b0;
					prev_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pins[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					lvl_q[gi] <= lvl_d[gi];
					prev_q[gi] <= lvl_q[gi];
				end
			end
		end
	endgenerate

	logic token_hi, token_fall, sclk_rise, sclk_fall, comp_rise, comp_fall;
	assign token_hi = lvl_q[PIN_TOKEN];
	assign token_fall = prev_q[PIN_TOKEN] && !lvl_q[PIN_TOKEN];
	assign sclk_rise = !prev_q[PIN_SCLK] && lvl_q[PIN_SCLK];
	assign sclk_fall = prev_q[PIN_SCLK] && !lvl_q[PIN_SCLK];
	assign comp_rise = !prev_q[PIN_COMP] && lvl_q[PIN_COMP];
	assign comp_fall = prev_q[PIN_COMP] && !lvl_q[PIN_COMP];

	// ----------------------------------------------------------------
	// read sequencing
	// ----------------------------------------------------------------
	read_state_type state_q, state_d;
	logic [EDGE_W-1:0] edge_q, edge_d;
	logic tok_out_q, tok_out_d;
	logic emit;
	logic [EDGE_W-1:0] slot_idx;
	logic [WORD_W-1:0] word;

	always_comb begin
		state_d = state_q;
		edge_d = edge_q;
		tok_out_d = tok_out_q;
		emit = 1'b0;
		if (token_hi) begin
			// token pulse restarts the read, whatever was in flight
			state_d = ST_ARMED;
			edge_d = EDGE_RESET;
			tok_out_d = 1'b1;
		end else begin
			unique case (state_q)
				ST_IDLE, ST_DONE: begin
				end
				ST_ARMED: begin
					if (token_fall) begin
						state_d = ST_READING;
					end
				end
				ST_READING: begin
					if (sclk_fall && tok_out_q) begin
						tok_out_d = 1'b0;
					end
					if (sclk_rise) begin
						edge_d = edge_q + 8'h01;
						emit = 1'b1;
						if (edge_d == LAST_EDGE) begin
							state_d = ST_DONE;
						end
					end
				end
			endcase
		end
	end

	// odd edges belong to the first device, even edges to the second;
	// within a device upper and lower alternate, so lower lags by two
	assign slot_idx = edge_d - 8'h01;
	assign word = {edge_d[0] ? 1'b0 : 1'b1,
		slot_idx[1],
		~slot_idx[1], ~slot_idx[6:2]};

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_q <= ST_IDLE;
			edge_q <= EDGE_RESET;
			tok_out_q <= 1'b0;
		end else begin
			state_q <= state_d;
			edge_q <= edge_d;
			tok_out_q <= tok_out_d;
		end
	end

	// ----------------------------------------------------------------
	// word rate watch, compensation events, status flags
	// ----------------------------------------------------------------
	logic [GAP_W-1:0] gap_q, gap_d;
	logic rate_q, rate_d, ovr_q, ovr_d, fwd_q, fwd_d, rev_q, rev_d;
	logic buf_ready;

	always_comb begin
		gap_d = emit ? 5'h00 : ((gap_q == GAP_MAX) ? gap_q : gap_q + 5'h01);
		rate_d = token_hi ? 1'b0 : rate_q;
		ovr_d = token_hi ? 1'b0 : ovr_q;
		// words closer than the shared converter's rate are flagged
		if (emit && gap_q < GAP_LIMIT) begin
			rate_d = 1'b1;
		end
		// the front end clock cannot be held, so a stall can only be reported
		if (emit && !buf_ready) begin
			ovr_d = 1'b1;
		end
		fwd_d = comp_fall;
		rev_d = comp_rise;
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			gap_q <= GAP_MAX;
			rate_q <= 1'b0;
			ovr_q <= 1'b0;
			fwd_q <= 1'b0;
			rev_q <= 1'b0;
		end else begin
			gap_q <= gap_d;
			rate_q <= rate_d;
			ovr_q <= ovr_d;
			fwd_q <= fwd_d;
			rev_q <= rev_d;
		end
	end

	// ----------------------------------------------------------------
	// output buffer and ports
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] out_word;

	word_skid_buffer u_buffer (
		.clk(CORE_CLK),
		.resetn(RESETN),
		.in_valid(emit),
		.in_ready(buf_ready),
		.in_word(word),
		.out_valid(WORD_VALID),
		.out_ready(WORD_READY),
		.out_word(out_word)
	);

	assign WORD_DEVICE = out_word[DEVICE_BIT];
	assign WORD_LOWER = out_word[LOWER_BIT];
	assign WORD_CHANNEL = out_word[CHANNEL_W-1:0];
	assign SCAN_TOKEN_OUT = tok_out_q;
	assign INJECT_FORWARD = fwd_q;
	assign INJECT_REVERSE = rev_q;
	assign READ_BUSY = (state_q == ST_READING);
	assign RATE_FAULT = rate_q;
	assign OVERRUN = ovr_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	logic [1:0] slot_q;
	logic seen_q;
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			slot_q <= 2'h0;
			seen_q <= 1'b0;
		end else begin
			if (emit) begin
				slot_q <= {word[LOWER_BIT], word[DEVICE_BIT]};
			end
			seen_q <= token_hi ? 1'b0 : (seen_q || emit);
		end
	end

	sequence comp_falls_s;
		comp_fall && !comp_rise;
	endsequence
	sequence one_pulse_fwd_s;
		INJECT_FORWARD ##1 !INJECT_FORWARD;
	endsequence
	sequence one_pulse_rev_s;
		INJECT_REVERSE ##1 !INJECT_REVERSE;
	endsequence

	token_drop_a: assert property (READ_BUSY && SCAN_TOKEN_OUT && sclk_fall && !token_hi
		|=> !SCAN_TOKEN_OUT)
		else $error("token output did not drop at first falling clock");
	read_start_a: assert property (token_hi |=> edge_q == EDGE_RESET && state_q == ST_ARMED)
		else $error("token pulse did not restart the read");
	second_first_a: assert property (emit && edge_d == 8'h02
		|-> word[DEVICE_BIT] && word[CHANNEL_W-1:0] == FIRST_CHANNEL)
		else $error("second device first word wrong");
	interleave_a: assert property (emit && seen_q |-> {word[LOWER_BIT], word[DEVICE_BIT]}
		== slot_q + 2'h1)
		else $error("interleave order broken");
	driver_range_a: assert property (emit |-> (word[LOWER_BIT]
		? word[CHANNEL_W-1:0] <= LOWER_TOP : word[CHANNEL_W-1:0] > LOWER_TOP))
		else $error("channel on wrong driver");
	edge_rate_a: assert property (emit |-> sclk_rise ##1 !emit)
		else $error("word not tied to a rising clock edge");
	inject_fwd_a: assert property (comp_falls_s |=> one_pulse_fwd_s)
		else $error("forward injection missing");
	inject_rev_a: assert property (comp_rise |=> one_pulse_rev_s ##0 !INJECT_FORWARD)
		else $error("reverse injection missing");
	rate_flag_a: assert property (emit && gap_q < GAP_LIMIT && !token_hi |=> RATE_FAULT [*2])
		else $error("word rate fault not flagged");
endmodule : cascaded_readout_sequencer

/* File: rtl/word_skid_buffer.sv */
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
module word_skid_buffer
	import cascade_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WORD_W-1:0] in_word,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WORD_W-1:0] out_word
);
	logic [WORD_W-1:0] mem_q [2];
	logic [WORD_W-1:0] mem_d [2];
	logic wr_q, wr_d, rd_q, rd_d;
	logic [1:0] count_q, count_d;
	logic push, pop;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_word = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		if (push) begin
			mem_d[wr_q] = in_word;
		end
		wr_d = push ? ~wr_q : wr_q;
		rd_d = pop ? ~rd_q : rd_q;
		count_d = count_q + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			count_q <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			count_q <= count_d;
		end
	end
endmodule : word_skid_buffer
